//--- rtl/ppm_consts.vh
// constants of the port pin function multiplexer
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH

// ------------------------------------------------------------
// bus
// ------------------------------------------------------------
`define PPM_AW 6
`define PPM_RESP_OK 2'h0
`define PPM_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PPM_OFS_LATCH 6'h00
`define PPM_OFS_DIR 6'h04
`define PPM_OFS_PULLUP 6'h08
`define PPM_OFS_ALT 6'h0C
`define PPM_OFS_ALTOUT 6'h10
`define PPM_OFS_CFG 6'h14
`define PPM_OFS_IN 6'h18
`define PPM_OFS_STATUS 6'h1C
`define PPM_OFS_MASK 6'h20

// ------------------------------------------------------------
// reset values, writable masks and the open-drain bits
// ------------------------------------------------------------
`define PPM_LATCH_MASK 24'hFFFFFF
`define PPM_DIR_RST 23'h7FFFFF
`define PPM_PU_MASK 23'h7C3FFF
`define PPM_OD_MASK 23'h03C000
`define PPM_ALT_MASK 31'h7FFC3FFF
`define PPM_AOUT_MASK 23'h0023B6
`define PPM_CFG_MASK 13'h1FFF
`define PPM_EV_MASK 7'h7F

// ------------------------------------------------------------
// bit positions in the 23-bit two-way pin vector, then the port 13 latch bit and the port 2 synchronised bits
// ------------------------------------------------------------
`define PPM_B_P00 5'h00
`define PPM_B_P01 5'h01
`define PPM_B_P10 5'h02
`define PPM_B_P11 5'h03
`define PPM_B_P12 5'h04
`define PPM_B_P13 5'h05
`define PPM_B_P14 5'h06
`define PPM_B_P15 5'h07
`define PPM_B_P16 5'h08
`define PPM_B_P17 5'h09
`define PPM_B_P30 5'h0A
`define PPM_B_P31 5'h0B
`define PPM_B_P32 5'h0C
`define PPM_B_P33 5'h0D
`define PPM_B_P7LO 5'h12
`define PPM_B_P7HI 5'h15
`define PPM_B_P120 5'h16
`define PPM_B_P13OUT 5'h17
`define PPM_B_P2LO 5'h17
`define PPM_B_P2HI 5'h1E

// ------------------------------------------------------------
// configuration and event fields
// ------------------------------------------------------------
`define PPM_CFG_TXSEL 4'hC
`define PPM_EV_KEY 3'h6

`endif

//--- rtl/ppm_sync.v
// two-stage synchroniser for pin levels
`timescale 1ns/100ps
module ppm_sync #(
  parameter W = 31
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // levels
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] stage1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // ppm_sync

//--- rtl/ppm_top.v
// port pin function multiplexer with axi4-lite registers
`timescale 1ns/100ps
`include "ppm_consts.vh"

// Operation
// - port 0: two bits, direction, pull-up
// - port 1: eight bits, direction, pull-up
// - port 2: eight inputs, alternate analog
// - port 3: four bits, direction, pull-up
// - port 6: four open-drain bits, no pull-up
// - port 7: four bits, direction, pull-up
// - port 7 alternate: key interrupt inputs
// - port 12: one bit, direction, pull-up
// - port 13: one output-only bit
// - per-pin choice of port or alternate, except port 6 and port 13
// - edge interrupts: rising, falling or both
// - port 0 pins feed wide timer
// - timer output pins input after reset
// - byte timer count inputs on ports 1, 3
// - serial data in, out, two-way clock
// - two-way bits reset as inputs
module ppm_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [`PPM_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`PPM_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt
  output reg irq,
  // two-way pins: ports 0, 1, 3, 6, 7, 12
  input wire [22:0] pin_in,
  output reg [22:0] pin_out,
  output reg [22:0] pin_oe_n,
  output reg [22:0] pin_pullup_en,
  // port 2 and port 13
  input wire [7:0] port2_in,
  output reg [7:0] analog_inputs,
  output reg output_only_bit,
  // peripheral outputs toward the pins
  input wire wide_timer_out,
  input wire byte_timer_a_out,
  input wire byte_timer_b_out,
  input wire h_timer_a_out,
  input wire h_timer_b_out,
  input wire sync_serial_data_out,
  input wire sync_serial_clock_out,
  input wire sync_serial_clock_oe,
  input wire async_serial_a_tx,
  input wire async_serial_b_tx,
  // pin levels toward the peripherals
  output reg wide_timer_count_capture_in,
  output reg wide_timer_capture_trigger_in,
  output reg byte_timer_a_count_in,
  output reg byte_timer_b_count_in,
  output reg sync_serial_data_in,
  output reg sync_serial_clock_in,
  output reg async_serial_a_rx,
  output reg async_serial_b_rx,
  output reg edge_irq_in_0,
  output reg [3:0] edge_irq_in_1_to_4,
  output reg edge_irq_in_5,
  output reg [3:0] key_irq_inputs
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function [31:0] merge_strb;
    input [31:0] old;
    input [31:0] upd;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge_strb[k*8 +: 8] = strb[k] ? upd[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  function addr_mapped;
    input [`PPM_AW-1:0] a;
    begin
      case (a)
        `PPM_OFS_LATCH, `PPM_OFS_DIR, `PPM_OFS_PULLUP, `PPM_OFS_ALT,
        `PPM_OFS_ALTOUT, `PPM_OFS_CFG, `PPM_OFS_IN, `PPM_OFS_STATUS,
        `PPM_OFS_MASK: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg [23:0] port_latch;
  reg [22:0] port_direction;
  reg [22:0] port_pullup_enable;
  reg [30:0] alt_mode;
  reg [22:0] alt_output_enable;
  reg [12:0] fn_config;
  reg [6:0] irq_status;
  reg [6:0] irq_mask;
  reg aw_hold;
  reg w_hold;
  reg [`PPM_AW-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [5:0] edge_prev;
  reg [3:0] key_prev;
  reg [31:0] next_rdata;
  reg [22:0] alt_val;
  reg [22:0] alt_drv;

  wire [30:0] sync_lvl;
  wire [22:0] pin_lvl;
  wire [7:0] p2_lvl;
  wire [22:0] pin_drv;
  wire [22:0] pin_val;
  wire [22:0] next_oe_n;
  wire [22:0] next_out;
  wire [22:0] next_pull;
  wire [5:0] edge_now;
  wire [5:0] edge_event;
  wire [3:0] key_now;
  wire key_event;
  wire [6:0] events;
  wire [31:0] wr_word;
  wire do_write;
  wire [6:0] status_clr;
  wire [22:0] od_mask;
  wire [22:0] pu_mask;
  // byte-merged write words, cut to each register's width where stored
  wire [31:0] m_latch, m_dir, m_pull, m_alt, m_aout, m_cfg, m_mask, m_clr;

  assign od_mask = `PPM_OD_MASK;
  assign pu_mask = `PPM_PU_MASK;

  // ------------------------------------------------------------
  // pin input synchronisation
  // ------------------------------------------------------------
  ppm_sync #(
    .W(31)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({port2_in, pin_in}),
    .dout(sync_lvl)
  );

  assign pin_lvl = sync_lvl[22:0];
  assign p2_lvl = sync_lvl[`PPM_B_P2HI:`PPM_B_P2LO];

  // ------------------------------------------------------------
  // alternate output selection
  // ------------------------------------------------------------
  always @* begin
    alt_val = 23'h000000;
    alt_val[`PPM_B_P01] = wide_timer_out;
    alt_val[`PPM_B_P10] = fn_config[`PPM_CFG_TXSEL] ? async_serial_a_tx
                                                    : sync_serial_clock_out;
    alt_val[`PPM_B_P12] = sync_serial_data_out;
    alt_val[`PPM_B_P13] = async_serial_b_tx;
    alt_val[`PPM_B_P15] = h_timer_a_out;
    alt_val[`PPM_B_P16] = h_timer_b_out;
    alt_val[`PPM_B_P17] = byte_timer_a_out;
    alt_val[`PPM_B_P33] = byte_timer_b_out;
    // only pins set to alternate with output enabled are peripheral-driven
    alt_drv = alt_mode[22:0] & alt_output_enable;
    // the serial clock pin drives only while the serial unit is clock master
    if (!fn_config[`PPM_CFG_TXSEL] && !sync_serial_clock_oe) begin
      alt_drv[`PPM_B_P10] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // per-pin drive, open drain and pull-up
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 23; gi = gi + 1) begin : g_pin
      // port mode drives when direction is output; alternate overrides
      assign pin_drv[gi] = alt_drv[gi] |
                           (~port_direction[gi] & ~alt_mode[gi]);
      assign pin_val[gi] = alt_drv[gi] ? alt_val[gi] : port_latch[gi];
      // open-drain bits only pull low
      assign next_oe_n[gi] = od_mask[gi] ? ~(pin_drv[gi] & ~pin_val[gi])
                                         : ~pin_drv[gi];
      assign next_out[gi] = od_mask[gi] ? 1'b0 : pin_val[gi];
      assign next_pull[gi] = pu_mask[gi] & ~pin_drv[gi] &
                             port_pullup_enable[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // edge and key interrupt detection
  // ------------------------------------------------------------
  assign edge_now = {pin_lvl[`PPM_B_P16], pin_lvl[`PPM_B_P33], pin_lvl[`PPM_B_P32],
                     pin_lvl[`PPM_B_P31], pin_lvl[`PPM_B_P30], pin_lvl[`PPM_B_P120]};

  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_edge
      // the selected sources sit at alt bits 22, 10..13, 8
      wire alt_on;
      assign alt_on = (gi == 0) ? alt_mode[`PPM_B_P120] :
                      (gi == 5) ? alt_mode[`PPM_B_P16] :
                      alt_mode[`PPM_B_P30 + gi - 1];
      assign edge_event[gi] = alt_on &
        ((edge_now[gi] & ~edge_prev[gi] & fn_config[2*gi]) |
         (~edge_now[gi] & edge_prev[gi] & fn_config[2*gi+1]));
    end
  endgenerate

  assign key_now = pin_lvl[`PPM_B_P7HI:`PPM_B_P7LO];
  // a key press pulls its pin low
  assign key_event = |(~key_now & key_prev &
                       alt_mode[`PPM_B_P7HI:`PPM_B_P7LO]);
  assign events = {key_event, edge_event};

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_word = w_data_q;
  assign m_latch = merge_strb({8'h00, port_latch}, wr_word, w_strb_q);
  assign m_dir = merge_strb({9'h000, port_direction}, wr_word, w_strb_q);
  assign m_pull = merge_strb({9'h000, port_pullup_enable}, wr_word, w_strb_q);
  assign m_alt = merge_strb({1'b0, alt_mode}, wr_word, w_strb_q);
  assign m_aout = merge_strb({9'h000, alt_output_enable}, wr_word, w_strb_q);
  assign m_cfg = merge_strb({19'h00000, fn_config}, wr_word, w_strb_q);
  assign m_mask = merge_strb({25'h0000000, irq_mask}, wr_word, w_strb_q);
  assign m_clr = merge_strb(32'h00000000, wr_word, w_strb_q);
  assign status_clr = (do_write && aw_addr_q == `PPM_OFS_STATUS) ? m_clr[6:0] : 7'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPM_RESP_OK;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= {`PPM_AW{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      port_latch <= 24'h000000;
      port_direction <= `PPM_DIR_RST;
      port_pullup_enable <= 23'h000000;
      alt_mode <= 31'h00000000;
      alt_output_enable <= 23'h000000;
      fn_config <= 13'h0000;
      irq_mask <= 7'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr_q) ? `PPM_RESP_OK : `PPM_RESP_SLVERR;
        case (aw_addr_q)
          `PPM_OFS_LATCH:
            port_latch <= m_latch[23:0] & `PPM_LATCH_MASK;
          `PPM_OFS_DIR:
            port_direction <= m_dir[22:0];
          `PPM_OFS_PULLUP:
            port_pullup_enable <= m_pull[22:0] & `PPM_PU_MASK;
          `PPM_OFS_ALT:
            alt_mode <= m_alt[30:0] & `PPM_ALT_MASK;
          `PPM_OFS_ALTOUT:
            alt_output_enable <= m_aout[22:0] & `PPM_AOUT_MASK;
          `PPM_OFS_CFG:
            fn_config <= m_cfg[12:0] & `PPM_CFG_MASK;
          `PPM_OFS_MASK:
            irq_mask <= m_mask[6:0] & `PPM_EV_MASK;
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    case (s_axi_araddr)
      `PPM_OFS_LATCH: next_rdata[23:0] = port_latch;
      `PPM_OFS_DIR: next_rdata[22:0] = port_direction;
      `PPM_OFS_PULLUP: next_rdata[22:0] = port_pullup_enable;
      `PPM_OFS_ALT: next_rdata[30:0] = alt_mode;
      `PPM_OFS_ALTOUT: next_rdata[22:0] = alt_output_enable;
      `PPM_OFS_CFG: next_rdata[12:0] = fn_config;
      // port 2 bits in analog mode read as zero
      `PPM_OFS_IN: next_rdata[30:0] = {p2_lvl & ~alt_mode[`PPM_B_P2HI:`PPM_B_P2LO],
                                       pin_lvl};
      `PPM_OFS_STATUS: next_rdata[6:0] = irq_status;
      `PPM_OFS_MASK: next_rdata[6:0] = irq_mask;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPM_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? `PPM_RESP_OK : `PPM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status, pins and peripheral feeds
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 7'h00;
      irq <= 1'b0;
      edge_prev <= 6'h00;
      key_prev <= 4'h0;
      pin_out <= 23'h000000;
      pin_oe_n <= `PPM_DIR_RST;
      pin_pullup_en <= 23'h000000;
      analog_inputs <= 8'h00;
      output_only_bit <= 1'b0;
      wide_timer_count_capture_in <= 1'b0;
      wide_timer_capture_trigger_in <= 1'b0;
      byte_timer_a_count_in <= 1'b0;
      byte_timer_b_count_in <= 1'b0;
      sync_serial_data_in <= 1'b0;
      sync_serial_clock_in <= 1'b0;
      async_serial_a_rx <= 1'b0;
      async_serial_b_rx <= 1'b0;
      edge_irq_in_0 <= 1'b0;
      edge_irq_in_1_to_4 <= 4'h0;
      edge_irq_in_5 <= 1'b0;
      key_irq_inputs <= 4'h0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~status_clr) | events;
      irq <= |(((irq_status & ~status_clr) | events) & irq_mask);
      edge_prev <= edge_now;
      key_prev <= key_now;
      pin_out <= next_out;
      pin_oe_n <= next_oe_n;
      pin_pullup_en <= next_pull;
      analog_inputs <= alt_mode[`PPM_B_P2HI:`PPM_B_P2LO];
      output_only_bit <= port_latch[`PPM_B_P13OUT];
      wide_timer_count_capture_in <= alt_mode[`PPM_B_P00] &
                                     pin_lvl[`PPM_B_P00];
      wide_timer_capture_trigger_in <= alt_mode[`PPM_B_P01] &
                                       pin_lvl[`PPM_B_P01];
      byte_timer_a_count_in <= alt_mode[`PPM_B_P17] & pin_lvl[`PPM_B_P17];
      byte_timer_b_count_in <= alt_mode[`PPM_B_P33] & pin_lvl[`PPM_B_P33];
      sync_serial_data_in <= alt_mode[`PPM_B_P11] & pin_lvl[`PPM_B_P11];
      sync_serial_clock_in <= alt_mode[`PPM_B_P10] & pin_lvl[`PPM_B_P10];
      async_serial_a_rx <= alt_mode[`PPM_B_P11] & pin_lvl[`PPM_B_P11];
      async_serial_b_rx <= alt_mode[`PPM_B_P14] & pin_lvl[`PPM_B_P14];
      edge_irq_in_0 <= alt_mode[`PPM_B_P120] & pin_lvl[`PPM_B_P120];
      edge_irq_in_1_to_4 <= alt_mode[`PPM_B_P33:`PPM_B_P30] &
                            pin_lvl[`PPM_B_P33:`PPM_B_P30];
      edge_irq_in_5 <= alt_mode[`PPM_B_P16] & pin_lvl[`PPM_B_P16];
      key_irq_inputs <= alt_mode[`PPM_B_P7HI:`PPM_B_P7LO] & key_now;
    end
  end

endmodule // ppm_top

//--- tb/ppm_props.sv
// assertion checker for the port pin function multiplexer
`timescale 1ns/100ps
module ppm_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // watched ports
  input wire s_axi_bvalid,
  input wire [22:0] pin_in,
  input wire [22:0] pin_out,
  input wire [22:0] pin_oe_n,
  input wire [22:0] pin_pullup_en,
  input wire [7:0] analog_inputs,
  input wire output_only_bit,
  input wire wide_timer_count_capture_in,
  input wire byte_timer_a_count_in,
  input wire [3:0] key_irq_inputs
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // register-driven outputs move only at or just after a write answer
  sequence s_wr_near;
    s_axi_bvalid || $past(s_axi_bvalid);
  endsequence
  property p_od; pin_out[17:14] == 4'h0 && pin_pullup_en[17:14] == 4'h0; endproperty
  a_od: assert property (p_od)
    else $error("port 6 driven high or pulled up");
  property p_pu_drv; (pin_pullup_en & ~pin_oe_n) == 23'h0; endproperty
  a_pu_drv: assert property (p_pu_drv)
    else $error("pull-up on a driven pin");
  property p_rst_in; $rose(aresetn) |-> pin_oe_n == 23'h7FFFFF && pin_pullup_en == 23'h0;
  endproperty
  a_rst_in: assert property (p_rst_in)
    else $error("pins not inputs after reset");
  property p_out13; $changed(output_only_bit) |-> s_wr_near; endproperty
  a_out13: assert property (p_out13)
    else $error("output-only bit moved without a write");
  property p_analog; $changed(analog_inputs) |-> s_wr_near; endproperty
  a_analog: assert property (p_analog)
    else $error("analog select moved without a write");
  property p_tmr_feed; wide_timer_count_capture_in |-> $past(pin_in[0], 3); endproperty
  a_tmr_feed: assert property (p_tmr_feed)
    else $error("wide timer input without pin level");
  property p_byte_feed; byte_timer_a_count_in |-> $past(pin_in[9], 3); endproperty
  a_byte_feed: assert property (p_byte_feed)
    else $error("byte timer input without pin level");
  property p_key_feed; (key_irq_inputs & ~$past(pin_in[21:18], 3)) == 4'h0; endproperty
  a_key_feed: assert property (p_key_feed)
    else $error("key input without pin level");
endmodule // ppm_props

bind ppm_top ppm_props u_props (
  .aclk, .aresetn, .s_axi_bvalid, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en,
  .analog_inputs, .output_only_bit, .wide_timer_count_capture_in, .byte_timer_a_count_in,
  .key_irq_inputs
);

//--- tb/ppm_board.sv
// board-side model of the circuitry on the two-way pins
`timescale 1ns/100ps
module ppm_board (
  // clock
  input wire aclk,
  // device pin drive
  input wire [22:0] pin_out,
  input wire [22:0] pin_oe_n,
  input wire [22:0] pin_pullup_en,
  // bench drivers on the board
  input wire [22:0] ext_en,
  input wire [22:0] ext_val,
  // resolved levels
  output wire [22:0] pin_level
);
  // port 6 only pulls low, so the board carries its pull-up
  localparam logic [22:0] BOARD_PU = 23'h03C000;
  logic [22:0] float_q = 23'h000000;
  wire [22:0] drv = ~pin_oe_n;
  wire [22:0] pulled = pin_pullup_en | BOARD_PU;
  // an undriven, unpulled line wanders every cycle
  always @(posedge aclk) float_q <= ~float_q;
  assign pin_level = (drv & pin_out) | (~drv & ext_en & ext_val)
    | (~drv & ~ext_en & (pulled | float_q));
endmodule // ppm_board

//--- tb/tb_top.sv
// self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
`include "ppm_consts.vh"
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] per = 10'h000;
  logic [7:0] port2_in = 8'hC3;
  logic [22:0] ext_en = 23'h7FFFFF, ext_val = 23'h000000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [22:0] pin_level, pin_out, pin_oe_n, pin_pullup_en;
  wire [7:0] analog_inputs;
  wire output_only_bit, wtc, wtt, bta, btb, ssd, ssc, ara, arb, ei0, ei5;
  wire [3:0] ei14, key;
  wire [17:0] feeds = {wtc, wtt, bta, btb, ssd, ssc, ara, arb, ei0, ei14, ei5, key};
  int n_fail = 0;
  int num_checks = 0;
  always #2.5 aclk = ~aclk;
  ppm_top uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .pin_in(pin_level), .pin_out, .pin_oe_n, .pin_pullup_en, .port2_in,
    .analog_inputs, .output_only_bit, .wide_timer_out(per[0]), .async_serial_a_tx(per[1]),
    .sync_serial_data_out(per[2]), .async_serial_b_tx(per[3]), .h_timer_a_out(per[4]),
    .h_timer_b_out(per[5]), .byte_timer_a_out(per[6]), .byte_timer_b_out(per[7]),
    .sync_serial_clock_out(per[8]), .sync_serial_clock_oe(per[9]),
    .wide_timer_count_capture_in(wtc), .wide_timer_capture_trigger_in(wtt),
    .byte_timer_a_count_in(bta), .byte_timer_b_count_in(btb), .sync_serial_data_in(ssd),
    .sync_serial_clock_in(ssc), .async_serial_a_rx(ara), .async_serial_b_rx(arb),
    .edge_irq_in_0(ei0), .edge_irq_in_1_to_4(ei14), .edge_irq_in_5(ei5), .key_irq_inputs(key)
  );
  ppm_board board (.aclk, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_en, .ext_val, .pin_level);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'h0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'h1, er});
  endtask
  task automatic axr(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'h0;
    chk({s_axi_rvalid, s_axi_rresp}, {1'h1, er});
    chk(s_axi_rdata, e);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    settle(0);
    chk(pin_oe_n, `PPM_DIR_RST);
    chk({output_only_bit, irq, pin_pullup_en}, 25'h0);
    axr(`PPM_OFS_DIR, {9'h0, `PPM_DIR_RST}, 2'h0);
    axr(`PPM_OFS_LATCH, 32'h0, 2'h0);
    axr(6'h24, 32'h0, `PPM_RESP_SLVERR);
    axw(6'h24, 32'hFFFFFFFF, `PPM_RESP_SLVERR);
  endtask
  task automatic t_port;
    logic [23:0] lv;
    ext_en <= 23'h0;
    axw(`PPM_OFS_DIR, 32'h0, 2'h0);
    for (int i = 0; i < 2; i++) begin
      lv = i ? 24'h75A5A5 : 24'h8A5A5A;
      axw(`PPM_OFS_LATCH, {8'h0, lv}, 2'h0);
      settle(3);
      chk(pin_out, lv[22:0] & ~`PPM_OD_MASK);
      chk(pin_oe_n, lv[22:0] & `PPM_OD_MASK);
      chk(output_only_bit, lv[23]);
      axr(`PPM_OFS_IN, {1'h0, port2_in, lv[22:0]}, 2'h0);
    end
  endtask
  task automatic t_pull;
    axw(`PPM_OFS_LATCH, 32'h0, 2'h0);
    axw(`PPM_OFS_DIR, {9'h0, `PPM_DIR_RST}, 2'h0);
    axw(`PPM_OFS_PULLUP, 32'hFFFFFFFF, 2'h0);
    settle(3);
    chk(pin_pullup_en, `PPM_PU_MASK);
    axr(`PPM_OFS_PULLUP, {9'h0, `PPM_PU_MASK}, 2'h0);
    axw(`PPM_OFS_DIR, 32'h7F0000, 2'h0);
    settle(3);
    chk(pin_pullup_en, `PPM_PU_MASK & 23'h7F0000);
    axr(`PPM_OFS_IN, {1'h0, port2_in, 23'h7F0000}, 2'h0);
    ext_en <= 23'h7FFFFF;
    axw(`PPM_OFS_DIR, {9'h0, `PPM_DIR_RST}, 2'h0);
  endtask
  task automatic t_alt_out;
    int pmap[8] = '{1, 2, 4, 5, 7, 8, 9, 13};
    axw(`PPM_OFS_CFG, 32'h1000, 2'h0);
    axw(`PPM_OFS_ALT, {9'h0, `PPM_AOUT_MASK}, 2'h0);
    axw(`PPM_OFS_ALTOUT, 32'hFFFFFFFF, 2'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      per <= 10'h001 << i;
      settle(3);
      chk(pin_out & `PPM_AOUT_MASK, 23'h1 << pmap[i]);
      chk(pin_oe_n & `PPM_AOUT_MASK, 23'h0);
    end
    axw(`PPM_OFS_CFG, 32'h0, 2'h0);
    @(posedge aclk);
    per <= 10'h100;
    settle(3);
    chk(pin_oe_n[2], 1'h1);
    @(posedge aclk);
    per <= 10'h300;
    settle(3);
    chk({pin_oe_n[2], pin_out[2]}, 2'h1);
    axw(`PPM_OFS_ALT, 32'h0, 2'h0);
    settle(3);
    chk(pin_oe_n, `PPM_DIR_RST);
  endtask
  task automatic t_feed;
    logic [22:0] v;
    logic [17:0] e;
    axw(`PPM_OFS_ALTOUT, 32'h0, 2'h0);
    axw(`PPM_OFS_ALT, 32'hFFFFFFFF, 2'h0);
    axr(`PPM_OFS_ALT, {1'h0, `PPM_ALT_MASK}, 2'h0);
    for (int i = 0; i < 2; i++) begin
      v = i ? ~23'h2A5A5A : 23'h2A5A5A;
      e = {v[0], v[1], v[9], v[13], v[3], v[2], v[3], v[6], v[22], v[13:10], v[8], v[21:18]};
      @(posedge aclk);
      ext_val <= v;
      settle(4);
      chk(feeds, e);
      chk(analog_inputs, 8'hFF);
      axr(`PPM_OFS_IN, {9'h0, v}, 2'h0);
    end
    axw(`PPM_OFS_ALT, 32'h0, 2'h0);
    settle(4);
    chk({analog_inputs, feeds}, 26'h0);
  endtask
  task automatic t_edge;
    @(posedge aclk);
    ext_val <= 23'h0;
    axw(`PPM_OFS_CFG, 32'hC09, 2'h0);
    axw(`PPM_OFS_ALT, 32'h440500, 2'h0);
    axw(`PPM_OFS_MASK, 32'h7F, 2'h0);
    settle(4);
    axw(`PPM_OFS_STATUS, 32'h7F, 2'h0);
    ext_val <= 23'h440500;
    settle(5);
    chk(irq, 1'h1);
    axr(`PPM_OFS_STATUS, 32'h21, 2'h0);
    axw(`PPM_OFS_STATUS, 32'h21, 2'h0);
    ext_val <= 23'h0;
    settle(5);
    axr(`PPM_OFS_STATUS, 32'h62, 2'h0);
    axw(`PPM_OFS_MASK, 32'h0, 2'h0);
    settle(2);
    chk(irq, 1'h0);
    axw(`PPM_OFS_STATUS, 32'h7F, 2'h0);
    axr(`PPM_OFS_STATUS, 32'h0, 2'h0);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_port();
    t_pull();
    t_alt_out();
    t_feed();
    t_edge();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
endmodule // tb_top
